// file: pkg/fcs_pkg.sv
// constants and types of the flash command controller
// assumes a 40 MHz core clock and an 8-bit parallel flash bus
`default_nettype none
package fcs_pkg;
  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  typedef logic [ADDR_W-1:0] fcs_addr_t;
  typedef logic [DATA_W-1:0] fcs_byte_t;
  localparam int POLL_BIT   = 7;
  localparam int LIMIT_BIT  = 5;
  // ==========================================================
  // command bytes
  localparam fcs_byte_t CMD_UNLOCK1  = 8'haa;
  localparam fcs_byte_t CMD_UNLOCK2  = 8'h55;
  localparam fcs_byte_t CMD_IDENT    = 8'h90;
  localparam fcs_byte_t CMD_PROGRAM  = 8'ha0;
  localparam fcs_byte_t CMD_BYPASS   = 8'h20;
  localparam fcs_byte_t CMD_ERASE    = 8'h80;
  localparam fcs_byte_t CMD_CHIP     = 8'h10;
  localparam fcs_byte_t CMD_SECTOR   = 8'h30;
  localparam fcs_byte_t CMD_SUSPEND  = 8'hb0;
  localparam fcs_byte_t CMD_RESUME   = 8'h30;
  localparam fcs_byte_t CMD_RESET    = 8'hf0;
  localparam fcs_byte_t CMD_BYP_EXIT = 8'h00;
  // ==========================================================
  // sequence step indices
  localparam logic [2:0] STEP_1 = 3'h0;
  localparam logic [2:0] STEP_2 = 3'h1;
  localparam logic [2:0] STEP_3 = 3'h2;
  localparam logic [2:0] STEP_4 = 3'h3;
  localparam logic [2:0] STEP_5 = 3'h4;
  localparam logic [2:0] STEP_6 = 3'h5;
  // ==========================================================
  // bus cycle timing
  localparam int CLK_MHZ   = 40;
  localparam int T_SU_NS   = 25;
  localparam int T_WR_NS   = 50;
  localparam int T_HD_NS   = 25;
  localparam int CNT_W     = 4;
  localparam int SU_CYC    = (T_SU_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC    = (T_WR_NS * CLK_MHZ + 999) / 1000;
  localparam int HD_CYC    = (T_HD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [CNT_W-1:0] SU_LOAD = CNT_W'(SU_CYC - 1);
  localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0] HD_LOAD = CNT_W'(HD_CYC - 1);
  localparam int POLL_W = 24;
  // ==========================================================
  // user operations
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_ID = 4'h2, OP_PROG = 4'h3,
    OP_BYP_EN = 4'h4, OP_BYP_PROG = 4'h5, OP_BYP_EXIT = 4'h6,
    OP_CHIP = 4'h7, OP_SECT = 4'h8, OP_SUSP = 4'h9, OP_RES = 4'ha
  } fcs_op_t;
endpackage
`default_nettype wire

// file: pkg/fcs_bus_if.sv
// request/answer link between the sequencer and the bus cycle engine
// assumes one request outstanding at a time
`timescale 1ns/1ps
`default_nettype none
interface fcs_bus_if;
  import fcs_pkg::*;
  logic      req;
  logic      wr;
  fcs_addr_t addr;
  fcs_byte_t wdata;
  fcs_byte_t rdata;
  logic      done;
  modport ctrl (output req, wr, addr, wdata, input rdata, done);
  modport eng  (input req, wr, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

// file: hdl/fcs_bus_cycle.sv
// one flash bus cycle per request: setup, strobe, hold
// assumes requests only arrive while the engine is idle
`timescale 1ns/1ps
`default_nettype none
module fcs_bus_cycle import fcs_pkg::*; (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  fcs_bus_if.eng          bus,
  input  wire fcs_byte_t  flash_dq_i,
  output fcs_addr_t       flash_addr_o,
  output fcs_byte_t       flash_dq_o,
  output logic            flash_dq_oe_o,
  output logic            flash_ce_n_o,
  output logic            flash_we_n_o,
  output logic            flash_oe_n_o
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b10, E_HOLD = 2'b11
  } fcs_eng_st_t;
  typedef struct packed {
    fcs_eng_st_t      st;
    logic [CNT_W-1:0] cnt;
    logic             wr;
    fcs_addr_t        addr;
    fcs_byte_t        wdata;
    fcs_byte_t        rdata;
    logic             ce_n;
    logic             we_n;
    logic             oe_n;
    logic             dq_oe;
    logic             done;
  } fcs_eng_t;
  localparam fcs_eng_t ENG_RST = '{st: E_IDLE, ce_n: 1'b1, we_n: 1'b1,
                                   oe_n: 1'b1, default: '0};
  fcs_eng_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      E_IDLE: if (bus.req) begin
        d.st    = E_SETUP;
        d.wr    = bus.wr;
        d.addr  = bus.addr;
        d.wdata = bus.wdata;
        d.ce_n  = 1'b0;
        d.dq_oe = bus.wr;
        d.cnt   = SU_LOAD;
      end
      E_SETUP: if (q.cnt == '0) begin
        d.st   = E_STROBE;
        d.we_n = !q.wr;
        d.oe_n = q.wr;
        d.cnt  = WR_LOAD;
      end else begin
        d.cnt = q.cnt - 4'h1;
      end
      E_STROBE: if (q.cnt == '0) begin
        d.st   = E_HOLD;
        d.we_n = 1'b1;
        d.oe_n = 1'b1;
        d.cnt  = HD_LOAD;
        if (!q.wr) begin
          d.rdata = flash_dq_i;
        end
      end else begin
        d.cnt = q.cnt - 4'h1;
      end
      E_HOLD: if (q.cnt == '0) begin
        // address and data held past the strobe edges
        d.st    = E_IDLE;
        d.ce_n  = 1'b1;
        d.dq_oe = 1'b0;
        d.done  = 1'b1;
      end else begin
        d.cnt = q.cnt - 4'h1;
      end
      default: d = ENG_RST;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      q <= ENG_RST;
    end else begin
      q <= d;
    end
  end

  assign bus.rdata     = q.rdata;
  assign bus.done      = q.done;
  assign flash_addr_o  = q.addr;
  assign flash_dq_o    = q.wdata;
  assign flash_dq_oe_o = q.dq_oe;
  assign flash_ce_n_o  = q.ce_n;
  assign flash_we_n_o  = q.we_n;
  assign flash_oe_n_o  = q.oe_n;

  // ==========================================================
  // checks
  property p_addr_stable;
    @(posedge core_clk_i) disable iff (reset_i)
      (!flash_we_n_o ##1 !flash_we_n_o) |-> $stable(flash_addr_o) && !flash_ce_n_o;
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write strobe");
  property p_data_hold;
    @(posedge core_clk_i) disable iff (reset_i)
      $rose(flash_we_n_o) |-> flash_dq_oe_o && $stable(flash_dq_o) && !flash_ce_n_o;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data not held at strobe rise");
  property p_no_clash;
    @(posedge core_clk_i) disable iff (reset_i)
      !flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("read and write strobes overlap");
endmodule
`default_nettype wire

// file: hdl/fcs_flash_ctrl.sv
// host side controller for a parallel nor flash: command sequences and status polling
// assumes the flash pins are wired straight to the device, dq resolved outside
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - one f0 write returns to array reads; sent after identification and on failure.
// - identification is aa, 55, 90 then one read at the chosen offset.
// - program is aa, 55, a0, then address and data write.
// - aa, 55, 20 enters bypass; only then a0 plus data programs.
// - bypass is left by writing 90 then 00.
// - erase is aa 55 80 aa 55, then 10 chip or 30 at sector.
// - plain reads need no commands; all other sequence cycles are writes, except the final identification read.
// - during programming polling bit reads inverted until done.
// - after polling bit turns true, data taken from the next read.
// - polling bit is reread after timing-limit flag is seen high.
module fcs_flash_ctrl import fcs_pkg::*; #(
  parameter logic [POLL_W-1:0] POLL_LIMIT = 24'hffffff
) (
  input  wire logic      core_clk_i,
  input  wire logic      reset_i,
  input  wire logic      cmd_valid_i,
  input  wire fcs_op_t   cmd_op_i,
  input  wire fcs_addr_t cmd_addr_i,
  input  wire fcs_byte_t cmd_data_i,
  input  wire logic      cmd_wait_i,
  output logic           cmd_ready_o,
  output logic           done_o,
  output logic           fail_o,
  output logic           refused_o,
  output fcs_byte_t      rdata_o,
  output logic           bypass_o,
  output logic           suspended_o,
  output logic           busy_o,
  input  wire fcs_byte_t flash_dq_i,
  output fcs_addr_t      flash_addr_o,
  output fcs_byte_t      flash_dq_o,
  output logic           flash_dq_oe_o,
  output logic           flash_ce_n_o,
  output logic           flash_we_n_o,
  output logic           flash_oe_n_o,
  input  wire logic      ready_busy_n_i
);
  // ==========================================================
  // state
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_SEQ = 4'b0001, S_SEQ_W = 4'b0010, S_POLL = 4'b0011,
    S_POLL_W = 4'b0100, S_FINAL = 4'b0101, S_FINAL_W = 4'b0110,
    S_RST = 4'b0111, S_RST_W = 4'b1000
  } fcs_st_t;
  typedef struct packed {
    fcs_st_t           st;
    fcs_op_t           op;
    fcs_addr_t         addr;
    fcs_byte_t         data;
    logic [2:0]        step;
    logic              wt;
    logic              bypass;
    logic              erasing;
    logic              seen_busy;
    logic              susp;
    logic              rechk;
    logic [POLL_W-1:0] poll_cnt;
    logic              req;
    logic              wr;
    fcs_addr_t         baddr;
    fcs_byte_t         bwdata;
    logic              ready;
    logic              done;
    logic              fail;
    logic              refused;
    fcs_byte_t         rdata;
    logic              busy;
  } fcs_ctl_t;
  localparam fcs_ctl_t CTL_RST = '{st: S_IDLE, op: OP_READ, ready: 1'b1, default: '0};
  fcs_ctl_t  q, d;
  fcs_bus_if bus ();

  // ==========================================================
  // sequence tables
  function automatic logic [2:0] seq_last(input fcs_op_t op);
    case (op)
      OP_ID, OP_PROG:       seq_last = STEP_4;
      OP_BYP_EN:            seq_last = STEP_3;
      OP_BYP_PROG:          seq_last = STEP_2;
      OP_BYP_EXIT:          seq_last = STEP_2;
      OP_CHIP, OP_SECT:     seq_last = STEP_6;
      default:              seq_last = STEP_1;
    endcase
  endfunction

  function automatic fcs_byte_t seq_byte(input fcs_op_t op, input logic [2:0] step,
                                         input fcs_byte_t data);
    seq_byte = '0;
    case (op)
      OP_RESET:    seq_byte = CMD_RESET;
      OP_SUSP:     seq_byte = CMD_SUSPEND;
      OP_RES:      seq_byte = CMD_RESUME;
      OP_BYP_PROG: seq_byte = (step == STEP_1) ? CMD_PROGRAM : data;
      OP_BYP_EXIT: seq_byte = (step == STEP_1) ? CMD_IDENT : CMD_BYP_EXIT;
      OP_READ:     seq_byte = '0;
      default: begin
        case (step)
          STEP_1: seq_byte = CMD_UNLOCK1;
          STEP_2: seq_byte = CMD_UNLOCK2;
          STEP_3: begin
            case (op)
              OP_ID:     seq_byte = CMD_IDENT;
              OP_PROG:   seq_byte = CMD_PROGRAM;
              OP_BYP_EN: seq_byte = CMD_BYPASS;
              default:   seq_byte = CMD_ERASE;
            endcase
          end
          STEP_4: seq_byte = (op == OP_PROG) ? data : CMD_UNLOCK1;
          STEP_5: seq_byte = CMD_UNLOCK2;
          default: seq_byte = (op == OP_CHIP) ? CMD_CHIP : CMD_SECTOR;
        endcase
      end
    endcase
  endfunction

  function automatic fcs_addr_t step_addr(input fcs_op_t op, input logic [2:0] step,
                                          input fcs_addr_t addr);
    logic uses;
    uses = (op == OP_READ) || (op == OP_ID) || (op == OP_PROG) ||
           (op == OP_BYP_PROG) || (op == OP_SECT);
    step_addr = (uses && step == seq_last(op)) ? addr : '0;
  endfunction

  function automatic logic step_rd(input fcs_op_t op, input logic [2:0] step);
    step_rd = (op == OP_READ) || (op == OP_ID && step == STEP_4);
  endfunction

  function automatic logic poll_exp(input fcs_op_t op, input fcs_byte_t data);
    // erase completes to one, program to the written bit
    if (op == OP_CHIP || op == OP_SECT) begin
      poll_exp = 1'b1;
    end else begin
      poll_exp = data[POLL_BIT];
    end
  endfunction

  function automatic logic op_legal(input fcs_op_t op, input logic byp,
                                    input logic ers, input logic sus);
    if (byp) begin
      op_legal = (op == OP_BYP_PROG) || (op == OP_BYP_EXIT);
    end else begin
      case (op)
        OP_BYP_PROG, OP_BYP_EXIT: op_legal = 1'b0;
        OP_SUSP:  op_legal = ers && !sus;
        OP_RES:   op_legal = sus;
        OP_CHIP, OP_SECT, OP_BYP_EN: op_legal = !ers;
        OP_PROG, OP_ID, OP_RESET:    op_legal = !ers || sus;
        OP_READ:  op_legal = 1'b1;
        default:  op_legal = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // sequencer
  always_comb begin
    logic fin;
    fin = 1'b0;
    d = q;
    d.req = 1'b0;
    d.done = 1'b0;
    d.refused = 1'b0;
    d.busy = !ready_busy_n_i;
    case (q.st)
      S_IDLE: begin
        if (q.erasing && !q.susp) begin
          if (!ready_busy_n_i) begin
            d.seen_busy = 1'b1;
          end else if (q.seen_busy) begin
            d.erasing = 1'b0;
          end
        end
        if (cmd_valid_i) begin
          if (op_legal(cmd_op_i, q.bypass, q.erasing, q.susp)) begin
            d.st       = S_SEQ;
            d.op       = cmd_op_i;
            d.addr     = cmd_addr_i;
            d.data     = cmd_data_i;
            d.wt       = cmd_wait_i || (cmd_op_i == OP_CHIP);
            d.step     = STEP_1;
            d.rechk    = 1'b0;
            d.fail     = 1'b0;
            d.poll_cnt = '0;
            d.ready    = 1'b0;
          end else begin
            d.refused = 1'b1;
          end
        end
      end
      S_SEQ: begin
        d.req    = 1'b1;
        d.wr     = !step_rd(q.op, q.step);
        d.baddr  = step_addr(q.op, q.step, q.addr);
        d.bwdata = seq_byte(q.op, q.step, q.data);
        d.st     = S_SEQ_W;
      end
      S_SEQ_W: if (bus.done) begin
        if (q.step != seq_last(q.op)) begin
          d.step = q.step + 3'h1;
          d.st   = S_SEQ;
        end else begin
          case (q.op)
            OP_READ: begin
              d.rdata = bus.rdata;
              fin = 1'b1;
            end
            OP_ID: begin
              d.rdata = bus.rdata;
              d.st = S_RST;
            end
            OP_PROG, OP_BYP_PROG, OP_CHIP, OP_SECT: begin
              if (q.op == OP_SECT) begin
                d.erasing   = 1'b1;
                d.seen_busy = 1'b0;
              end
              if (q.wt) begin
                d.st = S_POLL;
              end else begin
                fin = 1'b1;
              end
            end
            OP_BYP_EN: begin
              d.bypass = 1'b1;
              fin = 1'b1;
            end
            OP_BYP_EXIT: begin
              d.bypass = 1'b0;
              fin = 1'b1;
            end
            OP_SUSP: begin
              d.susp = 1'b1;
              fin = 1'b1;
            end
            OP_RES: begin
              d.susp      = 1'b0;
              d.seen_busy = 1'b0;
              fin = 1'b1;
            end
            default: fin = 1'b1;
          endcase
        end
      end
      S_POLL: begin
        // chip erase polls at the user address, which must be unprotected
        d.req      = 1'b1;
        d.wr       = 1'b0;
        d.baddr    = q.addr;
        d.poll_cnt = q.poll_cnt + 24'h1;
        d.st       = S_POLL_W;
      end
      S_POLL_W: if (bus.done) begin
        if (bus.rdata[POLL_BIT] == poll_exp(q.op, q.data)) begin
          d.st = S_FINAL;
        end else if (q.rechk || q.poll_cnt == POLL_LIMIT) begin
          // protected targets never reach true data; the limit ends them
          d.fail = 1'b1;
          d.st   = S_RST;
        end else begin
          d.rechk = bus.rdata[LIMIT_BIT];
          d.st    = S_POLL;
        end
      end
      S_FINAL: begin
        d.req   = 1'b1;
        d.wr    = 1'b0;
        d.baddr = q.addr;
        d.st    = S_FINAL_W;
      end
      S_FINAL_W: if (bus.done) begin
        d.rdata   = bus.rdata;
        d.erasing = q.erasing && (q.op != OP_SECT); // a program under suspend keeps the erase pending
        fin = 1'b1;
      end
      S_RST: begin
        d.req    = 1'b1;
        d.wr     = 1'b1;
        d.baddr  = '0;
        d.bwdata = CMD_RESET;
        d.st     = S_RST_W;
      end
      S_RST_W: if (bus.done) begin
        if (q.fail && q.op == OP_SECT) begin
          d.erasing = 1'b0;
        end
        fin = 1'b1;
      end
      default: d = CTL_RST;
    endcase
    if (fin) begin
      d.st    = S_IDLE;
      d.ready = 1'b1;
      d.done  = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      q <= CTL_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // bus engine and outputs
  assign bus.req   = q.req;
  assign bus.wr    = q.wr;
  assign bus.addr  = q.baddr;
  assign bus.wdata = q.bwdata;

  fcs_bus_cycle u_cycle (
    .core_clk_i    (core_clk_i),
    .reset_i       (reset_i),
    .bus           (bus),
    .flash_dq_i    (flash_dq_i),
    .flash_addr_o  (flash_addr_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_we_n_o  (flash_we_n_o),
    .flash_oe_n_o  (flash_oe_n_o)
  );

  assign cmd_ready_o = q.ready;
  assign done_o      = q.done;
  assign fail_o      = q.fail;
  assign refused_o   = q.refused;
  assign rdata_o     = q.rdata;
  assign bypass_o    = q.bypass;
  assign suspended_o = q.susp;
  assign busy_o      = q.busy;

  // ==========================================================
  // checks
  property p_id_reset;
    @(posedge core_clk_i) disable iff (reset_i)
      q.st == S_SEQ_W && q.op == OP_ID && bus.done && q.step == STEP_4
      |=> q.st == S_RST ##1 (q.req && q.bwdata == CMD_RESET);
  endproperty
  a_id_reset: assert property (p_id_reset) else $error("no reset after identification");
  property p_byp_refuse;
    @(posedge core_clk_i) disable iff (reset_i)
      cmd_valid_i && cmd_ready_o && cmd_op_i == OP_BYP_PROG && !bypass_o
      |=> refused_o && cmd_ready_o;
  endproperty
  a_byp_refuse: assert property (p_byp_refuse) else $error("bypass program outside bypass");
  property p_susp_refuse;
    @(posedge core_clk_i) disable iff (reset_i)
      cmd_valid_i && cmd_ready_o && cmd_op_i == OP_SUSP && !q.erasing |=> refused_o;
  endproperty
  a_susp_refuse: assert property (p_susp_refuse) else $error("suspend without sector erase");
  property p_res_refuse;
    @(posedge core_clk_i) disable iff (reset_i)
      cmd_valid_i && cmd_ready_o && cmd_op_i == OP_RES && !suspended_o |=> refused_o;
  endproperty
  a_res_refuse: assert property (p_res_refuse) else $error("resume while not suspended");
  property p_unlock_addr;
    @(posedge core_clk_i) disable iff (reset_i)
      q.req && q.wr && q.st == S_SEQ_W && q.step != seq_last(q.op) |-> q.baddr == '0;
  endproperty
  a_unlock_addr: assert property (p_unlock_addr) else $error("unlock cycle carries address");
  property p_next_read;
    @(posedge core_clk_i) disable iff (reset_i)
      q.st == S_POLL_W && bus.done && bus.rdata[POLL_BIT] == poll_exp(q.op, q.data)
      |=> q.st == S_FINAL ##1 (q.req && !q.wr);
  endproperty
  a_next_read: assert property (p_next_read) else $error("data taken before next read");
  property p_limit_recheck;
    @(posedge core_clk_i) disable iff (reset_i)
      q.st == S_POLL_W && bus.done && !q.rechk && q.poll_cnt != POLL_LIMIT
      && bus.rdata[LIMIT_BIT] && bus.rdata[POLL_BIT] != poll_exp(q.op, q.data)
      |=> q.st == S_POLL && !fail_o;
  endproperty
  a_limit_recheck: assert property (p_limit_recheck) else $error("failed without rereading");
  property p_chip_waits;
    @(posedge core_clk_i) disable iff (reset_i)
      q.st == S_SEQ_W && q.op == OP_CHIP && bus.done && q.step == STEP_6
      |=> q.st == S_POLL && !cmd_ready_o;
  endproperty
  a_chip_waits: assert property (p_chip_waits) else $error("chip erase not awaited");
endmodule
`default_nettype wire

// file: tb/fcs_flash_model.sv
// behavioural parallel flash on the far side of the controller
// assumes the controller's strobes and the core clock for busy timing
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model import fcs_pkg::*; #(
  parameter fcs_byte_t  MAKER = 8'h3c, // arbitrary
  parameter fcs_byte_t  PART  = 8'hc3, // arbitrary
  parameter logic [6:0] PROT  = 7'h01
) (
  input  wire logic      clk_i,
  input  wire fcs_addr_t addr_i,
  input  wire fcs_byte_t dq_i,
  input  wire logic      ce_n_i,
  input  wire logic      we_n_i,
  input  wire logic      oe_n_i,
  output fcs_byte_t      dq_o,
  output logic           ready_busy_n_o
);
  fcs_byte_t mem [int];
  fcs_addr_t a = '0;
  fcs_byte_t pd = '0, last = '0;
  int        st = 0, cnt = 0, pcnt = 0;
  logic      id = 0, byp = 0, ch = 0, sus = 0, tog = 0;
  always @(negedge clk_i) begin
    if (pcnt > 0) pcnt--;
    else if (cnt > 0 && !sus) cnt--;
  end
  assign ready_busy_n_o = !(pcnt > 0 || (cnt > 0 && !sus));
  always @(negedge we_n_i) if (!ce_n_i) a = addr_i;
  // ======================================
  // command decode
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (pcnt > 0) st = 0;
    else if (cnt > 0 && !sus) begin
      if (dq_i == CMD_SUSPEND && !ch) sus = 1;
    end else if (dq_i == CMD_RESET && !byp) begin
      st = 0;
      id = 0;
    end else case (st)
      0: if (sus && dq_i == CMD_RESUME) sus = 0;
         else if (byp) st = dq_i == CMD_PROGRAM ? 3 : dq_i == CMD_IDENT ? 7 : 0;
         else st = dq_i == CMD_UNLOCK1 ? 1 : 0;
      1: st = dq_i == CMD_UNLOCK2 ? 2 : 0;
      2: begin
        id = dq_i == CMD_IDENT;
        byp = dq_i == CMD_BYPASS;
        st = dq_i == CMD_PROGRAM ? 3 : dq_i == CMD_ERASE ? 4 : 0;
      end
      3: begin
        st = 0;
        pd = dq_i;
        pcnt = a[19:13] == PROT ? 40 : 20;
        if (a[19:13] != PROT) mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & dq_i;
      end
      4: st = dq_i == CMD_UNLOCK1 ? 5 : 0;
      5: st = dq_i == CMD_UNLOCK2 ? 6 : 0;
      6: begin
        st = 0;
        ch = dq_i == CMD_CHIP;
        cnt = (ch || dq_i == CMD_SECTOR) ? 400 : 0;
        if (cnt > 0) foreach (mem[k]) if (ch || (k >> 13) == int'(a[19:13])) mem[k] = 8'hff;
      end
      default: begin
        byp = dq_i != CMD_BYP_EXIT;
        st = 0;
      end
    endcase
  end
  // ======================================
  // read data and status
  always @(negedge oe_n_i) if (!ce_n_i) begin
    tog = ~tog;
    if (pcnt > 0) last = {~pd[7], tog, 6'h00};
    else if (cnt > 0 && !sus) last = {1'b0, tog, 6'h00};
    else if (id) last = addr_i[1:0] == 2'h0 ? MAKER : addr_i[1:0] == 2'h1 ? PART :
                        {7'h00, addr_i[19:13] == PROT};
    else last = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
  end
  // released bus shows the inverse of the last byte
  assign dq_o = (ce_n_i || oe_n_i) ? ~last : last;
endmodule
`default_nettype wire

// file: tb/fcs_flash_ctrl_tb.sv
// self-checking bench for the flash command controller
// assumes the behavioural flash model with its default codes
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl_tb import fcs_pkg::*;;
  typedef struct {fcs_op_t op; fcs_addr_t ad; fcs_byte_t dt; logic wt, rf, ck; fcs_byte_t ex; logic fl;} fcs_row_t;
  logic      core_clk = 0, reset = 1, cmd_valid = 0, cmd_wait = 0;
  logic      rdy, done, fail, refd, byp, susp, busy, dq_oe, ce_n, we_n, oe_n, rb_n;
  fcs_op_t   cmd_op = OP_READ;
  fcs_addr_t cmd_addr = '0, f_addr;
  fcs_byte_t cmd_data = '0, rdata, dq_out, dq_in;
  int        fail_count = 0, total_checks = 0, cycles = 0;
  fcs_row_t  rows [15] = '{
    '{OP_PROG, 20'h00010, 8'h5a, 1, 0, 1, 8'h5a, 0},
    '{OP_READ, 20'h00010, 8'h00, 0, 0, 1, 8'h5a, 0},
    '{OP_ID, 20'h00000, 8'h00, 0, 0, 1, 8'h3c, 0},
    '{OP_ID, 20'h00001, 8'h00, 0, 0, 1, 8'hc3, 0},
    '{OP_ID, 20'h02002, 8'h00, 0, 0, 1, 8'h01, 0},
    '{OP_ID, 20'h04002, 8'h00, 0, 0, 1, 8'h00, 0},
    '{OP_BYP_EN, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0},
    '{OP_READ, 20'h00010, 8'h00, 0, 1, 0, 8'h00, 0},
    '{OP_BYP_PROG, 20'h00020, 8'ha5, 1, 0, 1, 8'ha5, 0},
    '{OP_BYP_EXIT, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0},
    '{OP_READ, 20'h00020, 8'h00, 0, 0, 1, 8'ha5, 0},
    '{OP_RES, 20'h00000, 8'h00, 0, 1, 0, 8'h00, 0},
    '{OP_SUSP, 20'h00000, 8'h00, 0, 1, 0, 8'h00, 0},
    '{OP_BYP_PROG, 20'h00040, 8'h11, 1, 1, 0, 8'h00, 0},
    '{OP_RESET, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0}};
  fcs_flash_ctrl #(.POLL_LIMIT(24'h000100)) fcs_flash_ctrl_i (.core_clk_i(core_clk), .reset_i(reset),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_wait_i(cmd_wait),
    .cmd_ready_o(rdy), .done_o(done), .fail_o(fail), .refused_o(refd), .rdata_o(rdata), .bypass_o(byp),
    .suspended_o(susp), .busy_o(busy), .flash_dq_i(dq_in), .flash_addr_o(f_addr), .flash_dq_o(dq_out),
    .flash_dq_oe_o(dq_oe), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .ready_busy_n_i(rb_n));
  fcs_flash_model fcs_flash_model_i (.clk_i(core_clk), .addr_i(f_addr), .dq_i(dq_out), .ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .dq_o(dq_in), .ready_busy_n_o(rb_n));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one command through the user port, bounded wait for its answer
  task automatic run(input fcs_row_t r);
    cmd_valid <= 1;
    cmd_op <= r.op;
    cmd_addr <= r.ad;
    cmd_data <= r.dt;
    cmd_wait <= r.wt;
    do @(posedge core_clk); while (rdy !== 1'b1);
    cmd_valid <= 0;
    for (int n = 0; n < 4000 && !(done || refd); n++) @(posedge core_clk);
    chk(done | refd, 1'b1);
    chk(refd, r.rf);
    chk(fail, r.fl);
    if (r.ck) chk(rdata, r.ex);
  endtask
  always @(posedge core_clk) if (++cycles == 60000) begin
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 0;
    chk(rdy, 1);
    foreach (rows[i]) run(rows[i]);
    run('{OP_SECT, 20'h04000, 8'h00, 0, 0, 0, 8'h00, 0});
    chk(busy, 1);
    run('{OP_SUSP, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0});
    chk(susp, 1);
    run('{OP_READ, 20'h00010, 8'h00, 0, 0, 1, 8'h5a, 0});
    run('{OP_PROG, 20'h00030, 8'h0f, 1, 0, 1, 8'h0f, 0});
    run('{OP_RES, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0});
    chk(susp, 0);
    run('{OP_SUSP, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0});
    chk(susp, 1);
    run('{OP_RES, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0});
    for (int n = 0; n < 2000 && rb_n !== 1'b1; n++) @(posedge core_clk);
    chk(rb_n, 1);
    repeat (4) @(posedge core_clk);
    run('{OP_CHIP, 20'h00000, 8'h00, 1, 0, 0, 8'h00, 0});
    run('{OP_READ, 20'h00010, 8'h00, 0, 0, 1, 8'hff, 0});
    run('{OP_PROG, 20'h02005, 8'h00, 1, 0, 0, 8'h00, 1});
    run('{OP_BYP_EN, 20'h00000, 8'h00, 0, 0, 0, 8'h00, 0});
    chk(byp, 1);
    reset <= 1;
    repeat (2) @(posedge core_clk);
    reset <= 0;
    @(posedge core_clk);
    chk(byp, 0);
    chk(rdata, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
